// ---- spi_err_pkg.sv ----
// shared constants for the serial register interface error checker
package spi_err_pkg;
  localparam int             NUM_CHECKS     = 5;
  // bit positions shared by the enable and flag vectors
  localparam int             CHK_IGNORE     = 0;
  localparam int             CHK_BITCOUNT   = 1;
  localparam int             CHK_READ       = 2;
  localparam int             CHK_WRITE      = 3;
  localparam int             CHK_CRC        = 4;
  localparam logic [4:0]     EN_RESET       = 5'h01;
  localparam logic [4:0]     FLAG_RESET     = 5'h00;
  localparam logic [5:0]     CNT_CMD_END    = 6'h08;
  localparam logic [5:0]     CNT_DATA_END   = 6'h10;
  localparam logic [5:0]     CNT_CRC_END    = 6'h18;
  localparam logic [5:0]     CNT_MAX        = 6'h3F;
  localparam logic [7:0]     CRC_POLY       = 8'h07;
  localparam logic [7:0]     CRC_INIT       = 8'h00;
  localparam logic [7:0]     BYTE_ZERO      = 8'h00;
endpackage

// ---- bit_sync2.sv ----
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module bit_sync2 (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic rst_val_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic sync_r;
  // reset value fixed per instance by a tie, not sampled
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in ^ rst_val_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r ^ rst_val_in;
endmodule // bit_sync2
`default_nettype wire

// ---- spi_error_checker.sv ----
// serial register interface front end with access error checking
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - discarded-write check enable resets to one; hits raise their own flag.
// - writes arriving while fuse values are copied raise the discarded-write flag.
// - writes arriving during offset or gain calibration raise the discarded-write flag.
// - clock pulses are checked only with bit-count check and select framing enabled.
// - a framed access whose clock count is not a multiple of eight flags.
// - a write frame with too few clocks is aborted; register keeps old value.
// - reading a nonexistent address flags when its enable and framing are set.
// - writing a nonexistent or read-only address flags with its enable and framing.
// - checksum checked on writes, appended to reads; failing writes raise a flag.
// - bit-count, read, write and checksum enables reset to zero.
// - each enable is one bit; zero hides that error, one allows its flag.
module spi_error_checker (
  input  wire logic                                 clk_in,
  input  wire logic                                 sys_rst_in,
  input  wire logic                                 sclk_in,
  input  wire logic                                 cs_n_in,
  input  wire logic                                 mosi_in,
  output logic                                      miso_out,
  output logic                                      miso_oe_out,
  input  wire logic                                 select_framing_en_in,
  input  wire logic                                 en_load_in,
  input  wire logic [spi_err_pkg::NUM_CHECKS-1:0]   en_data_in,
  output logic      [spi_err_pkg::NUM_CHECKS-1:0]   check_en_out,
  input  wire logic [spi_err_pkg::NUM_CHECKS-1:0]   err_clear_in,
  output logic      [spi_err_pkg::NUM_CHECKS-1:0]   err_flags_out,
  input  wire logic                                 fuse_copy_busy_in,
  input  wire logic                                 calib_busy_in,
  output logic      [6:0]                           addr_out,
  output logic                                      read_cmd_out,
  input  wire logic                                 addr_exists_in,
  input  wire logic                                 addr_readonly_in,
  input  wire logic [7:0]                           rd_data_in,
  output logic                                      wr_strobe_out,
  output logic      [7:0]                           wr_data_out
);
  import spi_err_pkg::*;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  logic sclk_s, cs_n_s, mosi_s;
  logic sclk_d_r, cs_n_d_r;
  logic [4:0] en_r;
  logic [4:0] flag_r;
  logic [5:0] cnt_r;
  logic [23:0] rx_r;
  logic [7:0] cmd_r;
  logic [7:0] tx_r;
  logic [7:0] rdat_r;
  logic load_pend_r;
  logic miso_r;
  logic wr_strobe_r;
  logic [7:0] wr_data_r;

  // pins cross into clk_in through two flops each
  bit_sync2 u_sync_sclk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rst_val_in(1'b0),
                         .async_in(sclk_in), .sync_out(sclk_s));
  bit_sync2 u_sync_cs   (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rst_val_in(1'b1),
                         .async_in(cs_n_in), .sync_out(cs_n_s));
  bit_sync2 u_sync_mosi (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rst_val_in(1'b0),
                         .async_in(mosi_in), .sync_out(mosi_s));

  wire in_frame    = ~cs_n_s;
  wire frame_start = cs_n_d_r & ~cs_n_s;
  wire frame_end   = ~cs_n_d_r & cs_n_s;
  wire sclk_rise   = in_frame & ~sclk_d_r & sclk_s;
  wire sclk_fall   = in_frame & sclk_d_r & ~sclk_s;
  wire cnt_sat     = (cnt_r == CNT_MAX);
  wire cmd_done    = sclk_rise & (cnt_r == CNT_CMD_END - 6'h01);
  wire data_done   = sclk_rise & (cnt_r == CNT_DATA_END - 6'h01);

  wire crc_on      = en_r[CHK_CRC];
  wire is_write    = ~cmd_r[7];
  wire [5:0] need  = crc_on ? CNT_CRC_END : CNT_DATA_END;
  // the trailing byte positions depend on whether a checksum is expected
  wire [7:0] wr_byte  = crc_on ? rx_r[15:8] : rx_r[7:0];
  wire [7:0] wr_crc   = rx_r[7:0];
  wire crc_bad        = crc_on & (crc8({cmd_r, wr_byte}) != wr_crc);
  wire busy           = fuse_copy_busy_in | calib_busy_in;
  wire short_frame    = cnt_r < need;
  wire count_bad      = cnt_r[2:0] != 3'h0;
  wire bitcount_armed = en_r[CHK_BITCOUNT] & select_framing_en_in;
  wire addr_bad_wr    = ~addr_exists_in | addr_readonly_in;
  wire wr_end         = frame_end & is_write & (cnt_r >= CNT_CMD_END);

  wire ev_ignore   = wr_end & ~short_frame & busy & en_r[CHK_IGNORE];
  wire ev_bitcount = frame_end & (cnt_r != 6'h00) & count_bad & bitcount_armed;
  wire ev_read     = load_pend_r & ~is_write & ~addr_exists_in
                     & en_r[CHK_READ] & select_framing_en_in;
  wire ev_write    = wr_end & ~short_frame & addr_bad_wr
                     & en_r[CHK_WRITE] & select_framing_en_in;
  wire ev_crc      = wr_end & ~short_frame & crc_bad;
  wire [4:0] ev    = {ev_crc, ev_write, ev_read, ev_bitcount, ev_ignore};

  // short writes are dropped whether or not the count check is armed; too few
  // clocks cannot complete the data byte, or the checksum byte when enabled, so the write never happens
  wire commit      = wr_end & ~short_frame & ~busy & ~addr_bad_wr & ~crc_bad;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_r <= EN_RESET;
    end else if (en_load_in) begin
      en_r <= en_data_in;
    end
  end

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_r <= FLAG_RESET;
    end else begin
      flag_r <= (flag_r & ~err_clear_in) | ev;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // one counter per frame, restarted by the select edge
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 6'h00;
      rx_r  <= 24'h000000;
    end else if (frame_start) begin
      cnt_r <= 6'h00;
    end else if (sclk_rise) begin
      cnt_r <= cnt_sat ? cnt_r : cnt_r + 6'h01;
      // clocks past the needed count are ignored so the data byte stays in place
      if (short_frame) begin
        rx_r <= {rx_r[22:0], mosi_s};
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_r       <= BYTE_ZERO;
      load_pend_r <= 1'b0;
    end else begin
      load_pend_r <= cmd_done;
      if (cmd_done) begin
        cmd_r <= {rx_r[6:0], mosi_s};
      end
    end
  end

  // read data loads one cycle after the address settles; checksum follows the byte
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_r   <= BYTE_ZERO;
      rdat_r <= BYTE_ZERO;
      miso_r <= 1'b0;
    end else if (load_pend_r) begin
      tx_r   <= is_write ? BYTE_ZERO : rd_data_in;
      rdat_r <= is_write ? BYTE_ZERO : rd_data_in;
    end else if (data_done) begin
      tx_r <= (crc_on & ~is_write) ? crc8({cmd_r, rdat_r}) : BYTE_ZERO;
    end else if (sclk_fall) begin
      miso_r <= (cnt_r >= CNT_CMD_END) ? tx_r[7] : 1'b0;
      tx_r   <= (cnt_r >= CNT_CMD_END) ? {tx_r[6:0], 1'b0} : tx_r;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_strobe_r <= 1'b0;
      wr_data_r   <= BYTE_ZERO;
    end else begin
      wr_strobe_r <= commit;
      if (commit) begin
        wr_data_r <= wr_byte;
      end
    end
  end

  assign miso_out      = miso_r;
  assign miso_oe_out   = in_frame & ~is_write & (cnt_r >= CNT_CMD_END);
  assign check_en_out  = en_r;
  assign err_flags_out = flag_r;
  assign addr_out      = cmd_r[6:0];
  assign read_cmd_out  = cmd_r[7];
  assign wr_strobe_out = wr_strobe_r;
  assign wr_data_out   = wr_data_r;

  a_flag_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(flag_r[CHK_READ]) && !$past(err_clear_in[CHK_READ]) |-> flag_r[CHK_READ])
    else $error("read flag dropped without clear");
  a_count_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    frame_end && bitcount_armed && cnt_r == 6'h09 |=> flag_r[CHK_BITCOUNT])
    else $error("odd clock count not flagged");
  a_count_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !select_framing_en_in && !flag_r[CHK_BITCOUNT] |=> !flag_r[CHK_BITCOUNT])
    else $error("count flag set without framing enable");
  a_short_abort: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    frame_end && cnt_r < CNT_DATA_END |=> !wr_strobe_out)
    else $error("short write frame committed");
  a_busy_discard: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    wr_end && !short_frame && busy && en_r[CHK_IGNORE] |=> flag_r[CHK_IGNORE] && !wr_strobe_out)
    else $error("busy write not discarded");
  a_bad_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cmd_done && rx_r[6] ##1 !addr_exists_in && en_r[CHK_READ] && select_framing_en_in
    |=> flag_r[CHK_READ])
    else $error("bad read not flagged");
  a_bad_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_end && !short_frame && addr_readonly_in |=> !wr_strobe_out)
    else $error("read-only write committed");
  a_crc_fail: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_end && !short_frame && crc_bad |=> flag_r[CHK_CRC] && !wr_strobe_out)
    else $error("checksum failure not handled");
  a_enable_reset: assert property (@(posedge clk_in)
    $fell(sys_rst_in) |-> en_r == EN_RESET)
    else $error("enables wrong after reset");
  a_enable_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    en_load_in |=> check_en_out == $past(en_data_in))
    else $error("enable load lost");

  c_write_ok: cover property (@(posedge clk_in) disable iff (sys_rst_in) wr_strobe_out);
  c_count_err: cover property (@(posedge clk_in) disable iff (sys_rst_in) ev_bitcount);
  c_read_frame: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    miso_oe_out && data_done);
  c_busy_write: cover property (@(posedge clk_in) disable iff (sys_rst_in) ev_ignore);
endmodule // spi_error_checker
`default_nettype wire

// ---- host_spi_model.sv ----
// host serial controller model for the register link
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_in
);
  // an undriven data line reads back inverted so a late enable shows up
  wire miso_line = miso_oe_in ? miso_in : ~miso_in;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one chip-select frame per access; clock idles low between frames
  task automatic xfer(input logic [23:0] tx, input integer nb, output logic [23:0] rx);
    rx = 24'h000000;
    cs_n_out = 1'b0;
    #80;
    for (int i = 0; i < nb; i++) begin
      mosi_out = tx[23-i];
      #80 sclk_out = 1'b1;
      rx = {rx[22:0], miso_line};
      #80 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
    // released line shows no stale value
    mosi_out = ~mosi_out;
    #100;
  endtask
endmodule // host_spi_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the access error checker
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spi_err_pkg::*;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, sclk_in, cs_n_in, mosi_in, miso_out;
  logic        miso_oe_out, read_cmd_out, wr_strobe_out;
  logic        select_framing_en_in = 1'b0, en_load_in = 1'b0;
  logic        fuse_copy_busy_in = 1'b0, calib_busy_in = 1'b0;
  logic        addr_exists_in = 1'b1, addr_readonly_in = 1'b0;
  logic [4:0]  en_data_in = 5'h00, err_clear_in = 5'h00, check_en_out, err_flags_out;
  logic [6:0]  addr_out, a;
  logic [7:0]  rd_data_in = 8'h00, wr_data_out, d;
  logic [23:0] rx;
  integer      err_count = 0, tests_run = 0, cycles = 0, exp_flags = 0, n;
  integer      seed = 32'hF819E68B;
  logic [7:0]  wq[$];
  spi_error_checker uut (.clk_in, .sys_rst_in, .sclk_in, .cs_n_in, .mosi_in, .miso_out,
    .miso_oe_out, .select_framing_en_in, .en_load_in, .en_data_in, .check_en_out,
    .err_clear_in, .err_flags_out, .fuse_copy_busy_in, .calib_busy_in, .addr_out,
    .read_cmd_out, .addr_exists_in, .addr_readonly_in, .rd_data_in, .wr_strobe_out,
    .wr_data_out);
  host_spi_model host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in),
    .miso_in(miso_out), .miso_oe_in(miso_oe_out));
  always #2 clk_in = ~clk_in;
  task automatic close_out();
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flags();
    chk("err_flags", exp_flags[4:0], err_flags_out);
  endtask
  task automatic tick(input integer c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task automatic set_en(input logic [4:0] v);
    en_data_in = v;
    en_load_in = 1'b1;
    tick(1);
    en_load_in = 1'b0;
    tick(1);
    chk("check_en", v, check_en_out);
  endtask
  task automatic clear();
    err_clear_in = 5'h1F;
    tick(1);
    err_clear_in = 5'h00;
    tick(1);
    exp_flags = 0;
  endtask
  task automatic acc(input logic [23:0] tx, input integer nb);
    host.xfer(tx, nb, rx);
    tick(8);
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end
  // writes commit in order; a strobe with nothing expected is a leak
  always @(posedge clk_in) begin
    if (wr_strobe_out === 1'b1) begin
      if (wq.size() == 0) chk("write_strobe", 24'h0, 24'h1);
      else chk("write_data", wq.pop_front(), wr_data_out);
    end
  end
  initial begin
    tick(8);
    sys_rst_in = 1'b0;
    tick(4);
    chk("check_en", 24'h000001, check_en_out);
    chk_flags();
    for (int k = 0; k < 3; k++) begin
      clear();
      fuse_copy_busy_in = (k == 1);
      calib_busy_in = (k == 2);
      d = 8'($random(seed));
      if (k == 0) wq.push_back(d);
      else exp_flags |= 1;
      acc({1'b0, 7'h05, d, 8'h00}, 16);
      chk_flags();
    end
    calib_busy_in = 1'b0;
    d = 8'($random(seed));
    wq.push_back(d);
    acc({1'b0, 7'h06, d, 8'h00}, 16);
    chk_flags();
    for (int k = 0; k < 4; k++) begin
      clear();
      set_en(k[1] ? 5'h03 : 5'h01);
      select_framing_en_in = k[0];
      n = 9 + {$random(seed)} % 7;
      if (k == 3) exp_flags |= 2;
      acc({1'b0, 7'h05, 16'hA5A5}, n);
      chk_flags();
    end
    // extra clocks past the data byte are ignored
    d = 8'($random(seed));
    wq.push_back(d);
    acc({1'b0, 7'h05, d, 8'hFF}, 24);
    chk_flags();
    clear();
    set_en(5'h0C);
    for (int k = 0; k < 4; k++) begin
      select_framing_en_in = k[1];
      addr_exists_in = k[0];
      addr_readonly_in = k[0];
      if (k[1]) exp_flags |= k[0] ? 8 : 4;
      acc({~k[0], 7'h7F, 16'h0000}, 16);
      chk_flags();
    end
    addr_exists_in = 1'b1;
    addr_readonly_in = 1'b0;
    clear();
    for (int k = 0; k < 2; k++) begin
      set_en(k ? 5'h10 : 5'h00);
      a = 7'($random(seed));
      rd_data_in = 8'($random(seed));
      acc({1'b1, a, 16'h0000}, 16 + 8 * k);
      chk("read_addr", {1'b1, a}, {read_cmd_out, addr_out});
      if (k == 0) chk("read_data", rd_data_in, rx[7:0]);
      else chk("read_crc", {rd_data_in, crc8({1'b1, a, rd_data_in})}, rx[15:0]);
    end
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      if (k == 0) wq.push_back(d);
      else exp_flags |= 16;
      acc({1'b0, 7'h05, d, crc8({8'h05, d}) ^ k[7:0]}, 24);
      chk_flags();
    end
    // all checks off: busy write to a missing address and a bad read leave flags alone
    set_en(5'h00);
    fuse_copy_busy_in = 1'b1;
    addr_exists_in = 1'b0;
    acc({1'b0, 7'h05, 16'h5A5A}, 16);
    acc({1'b1, 7'h7F, 16'h0000}, 16);
    fuse_copy_busy_in = 1'b0;
    addr_exists_in = 1'b1;
    chk_flags();
    chk("pending_writes", 24'h0, 24'(wq.size()));
    close_out();
  end
endmodule // testbench
`default_nettype wire
